/* File: design/i2c_master_tx.sv */
// Two-wire bus master transmitter with control, status and data registers
`timescale 1ns/1ps
`default_nettype none

module i2c_master_tx
    import i2c_mstx_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Register port
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Interrupt request
    output logic            irq,
    // Two-wire pins, enable low while pulling low
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOeN,
    input  wire logic       sclIn,
    output logic            sclOut,
    output logic            sclOeN
);

    typedef struct packed {
        state_t     st;
        logic [1:0] q;
        logic [4:0] tick;
        logic [3:0] bitCnt;
        logic [7:0] data;
        logic [7:0] code;
        logic [7:0] rdata;
        logic [1:0] presc;
        logic       flag;
        logic       ackEn;
        logic       startReq;
        logic       stopReq;
        logic       wcol;
        logic       en;
        logic       ie;
        logic       addrPh;
        logic       rep;
        logic       rx;
        logic       busy;
        logic       sdaDrv;
        logic       sclDrv;
        logic       sdaMeta;
        logic       sdaSync;
        logic       sdaPrev;
        logic       sclMeta;
        logic       sclSync;
    } regs_t;

    regs_t r;
    regs_t next_r;
    logic  tickEnd;
    logic  busFree;

    assign tickEnd = (r.tick == QTR_LAST);
    assign busFree = !r.busy && r.sdaSync && r.sclSync;

    always_comb
    begin
        next_r = r;
        next_r.sdaMeta = sdaIn;
        next_r.sdaSync = r.sdaMeta;
        next_r.sdaPrev = r.sdaSync;
        next_r.sclMeta = sclIn;
        next_r.sclSync = r.sclMeta;
        next_r.rdata = 8'h00;
        // Bus watcher: another master may own the bus
        if (r.sclSync && r.sdaPrev && !r.sdaSync)
            next_r.busy = 1'b1;
        else if (r.sclSync && !r.sdaPrev && r.sdaSync)
            next_r.busy = 1'b0;
        if (rd)
            case (addr)
                ADDR_CTRL: next_r.rdata = {r.flag, r.ackEn, r.startReq, r.stopReq,
                                           r.wcol, r.en, 1'b0, r.ie};
                ADDR_STAT: next_r.rdata = r.code | {6'h00, r.presc};
                ADDR_DATA: next_r.rdata = r.data;
                default:   next_r.rdata = 8'h00;
            endcase
        if (wr)
        begin
            case (addr)
                ADDR_CTRL:
                begin
                    next_r.ackEn = wdata[ACKEN_POS];
                    next_r.startReq = wdata[START_POS];
                    next_r.stopReq = wdata[STOP_POS];
                    next_r.en = wdata[EN_POS];
                    next_r.ie = wdata[IE_POS];
                    if (wdata[FLAG_POS])
                        next_r.flag = 1'b0;
                end
                ADDR_STAT: next_r.presc = wdata[1:0];
                ADDR_DATA:
                begin
                    next_r.wcol = !r.flag;
                    if (r.flag)
                        next_r.data = wdata;
                end
                default: ;
            endcase
        end
        next_r.tick = 5'h00;
        next_r.q = 2'h0;
        if (r.st == START || r.st == BIT || r.st == STOP)
        begin
            next_r.tick = tickEnd ? 5'h00 : 5'(r.tick + 5'h01);
            next_r.q = tickEnd ? 2'(r.q + 2'h1) : r.q;
        end
        // Hardware flag sets come last so a set beats a same-cycle clear
        case (r.st)
            IDLE:
                if (r.en && r.startReq && !r.flag)
                    next_r.st = WAITFREE;
            WAITFREE:
                if (busFree)
                begin
                    next_r.st = START;
                    next_r.rep = 1'b0;
                end
            HOLD:
                if (!r.flag)
                begin
                    if (r.stopReq)
                    begin
                        next_r.st = STOP;
                        next_r.sdaDrv = 1'b1;
                    end
                    else if (r.startReq)
                    begin
                        next_r.st = START;
                        next_r.rep = 1'b1;
                    end
                    else if (!r.rx)
                    begin
                        next_r.st = BIT;
                        next_r.bitCnt = 4'h0;
                        next_r.sdaDrv = !r.data[7];
                    end
                end
            LOST:
                if (!r.flag)
                    next_r.st = r.startReq ? WAITFREE : IDLE;
            START:
                if (tickEnd)
                begin
                    case (r.q)
                        2'h0: next_r.sdaDrv = 1'b0;
                        2'h1: next_r.sclDrv = 1'b0;
                        2'h2: next_r.sdaDrv = 1'b1;
                        default:
                        begin
                            next_r.sclDrv = 1'b1;
                            next_r.flag = 1'b1;
                            next_r.code = r.rep ? ST_REP : ST_START;
                            next_r.addrPh = 1'b1;
                            next_r.rx = 1'b0;
                            next_r.st = HOLD;
                        end
                    endcase
                end
            BIT:
                if (tickEnd)
                begin
                    case (r.q)
                        2'h0: next_r.sdaDrv = (r.bitCnt == ACK_BIT) ? 1'b0
                                            : !r.data[3'(4'h7 - r.bitCnt)];
                        2'h1: next_r.sclDrv = 1'b0;
                        2'h3:
                        begin
                            next_r.sclDrv = 1'b1;
                            if (r.bitCnt == ACK_BIT)
                            begin
                                next_r.flag = 1'b1;
                                next_r.st = HOLD;
                                next_r.addrPh = 1'b0;
                                if (r.addrPh && r.data[0])
                                begin
                                    next_r.rx = 1'b1;
                                    next_r.code = r.sdaSync ? ST_AR_NACK : ST_AR_ACK;
                                end
                                else if (r.addrPh)
                                    next_r.code = r.sdaSync ? ST_AW_NACK : ST_AW_ACK;
                                else
                                    next_r.code = r.sdaSync ? ST_D_NACK : ST_D_ACK;
                            end
                            else if (!r.sdaDrv && !r.sdaSync)
                            begin
                                next_r.sclDrv = 1'b0;
                                next_r.flag = 1'b1;
                                next_r.code = ST_LOST;
                                next_r.st = LOST;
                            end
                            else
                                next_r.bitCnt = 4'(r.bitCnt + 4'h1);
                        end
                        default: ;
                    endcase
                end
            STOP:
                if (tickEnd)
                begin
                    case (r.q)
                        2'h1: next_r.sclDrv = 1'b0;
                        2'h2: next_r.sdaDrv = 1'b0;
                        2'h3:
                        begin
                            next_r.stopReq = 1'b0;
                            next_r.st = r.startReq ? WAITFREE : IDLE;
                            next_r.code = ST_IDLE;
                        end
                        default: ;
                    endcase
                end
            default: next_r.st = IDLE;
        endcase
        // Disabled unit lets go of both wires at once
        if (!r.en)
        begin
            next_r.st = IDLE;
            next_r.sdaDrv = 1'b0;
            next_r.sclDrv = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            r <= '0;
        else
            r <= next_r;
    end

    assign rdata = r.rdata;
    assign irq = r.flag && r.ie;
    assign sdaOut = 1'b0;
    assign sclOut = 1'b0;
    assign sdaOeN = !r.sdaDrv;
    assign sclOeN = !r.sclDrv;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence startEnd;
        r.st == START && r.q == 2'h3 && tickEnd && r.en;
    endsequence
    sequence ackEnd;
        r.st == BIT && r.q == 2'h3 && tickEnd && r.bitCnt == ACK_BIT && r.en;
    endsequence
    sequence holdClear;
        r.st == HOLD && !r.flag && r.en;
    endsequence

    startCode_a: assert property (startEnd |=> r.flag && r.st == HOLD &&
        (r.code == ST_START || r.code == ST_REP))
        else $error("start did not report its code");
    waitFree_a: assert property (r.st == WAITFREE && !busFree && r.en
        |=> r.st == WAITFREE)
        else $error("start left the wait while bus busy");
    wcolSet_a: assert property (wr && addr == ADDR_DATA && !r.flag
        |=> r.wcol && r.data == $past(r.data))
        else $error("colliding data write not dropped");
    holdStill_a: assert property (r.st == HOLD && r.flag && r.en
        |=> r.st == HOLD && $stable(r.sdaDrv) && $stable(r.sclDrv))
        else $error("bus moved while flag set");
    addrCode_a: assert property (ackEnd and r.addrPh && !r.data[0]
        |=> r.code == ($past(r.sdaSync) ? ST_AW_NACK : ST_AW_ACK))
        else $error("wrong address status");
    dataCode_a: assert property (ackEnd and !r.addrPh
        |=> r.code == ($past(r.sdaSync) ? ST_D_NACK : ST_D_ACK) && r.flag)
        else $error("wrong data status");
    sendByte_a: assert property (holdClear and !r.stopReq && !r.startReq && !r.rx
        |=> r.st == BIT && r.bitCnt == 4'h0 ##[1:300] r.st == BIT && r.q == 2'h2)
        else $error("loaded byte not sent");
    stopAuto_a: assert property (holdClear and r.stopReq
        |=> r.st == STOP ##[120:130] !r.stopReq && r.st != STOP)
        else $error("stop bit did not self-clear");
    stopStart_a: assert property (r.st == STOP && r.q == 2'h3 && tickEnd
        && r.startReq && r.en |=> r.st == WAITFREE)
        else $error("no start after stop");
    lostRel_a: assert property (r.st == BIT && r.q == 2'h3 && tickEnd
        && r.bitCnt != ACK_BIT && !r.sdaDrv && !r.sdaSync && r.en
        |=> r.code == ST_LOST && !r.sclDrv && !r.sdaDrv && r.flag)
        else $error("arbitration loss not handled");
    flagClr_a: assert property (wr && addr == ADDR_CTRL && wdata[FLAG_POS]
        && r.st == HOLD |=> !r.flag)
        else $error("flag not cleared by writing one");

endmodule // i2c_master_tx
`default_nettype wire

/* File: include/i2c_mstx_pkg.sv */
// Constants and types for the two-wire master transmitter
package i2c_mstx_pkg;
    // Register port addresses
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_STAT = 2'h1;
    localparam logic [1:0] ADDR_DATA = 2'h2;
    // Control register fields
    localparam int FLAG_POS  = 7;
    localparam int ACKEN_POS = 6;
    localparam int START_POS = 5;
    localparam int STOP_POS  = 4;
    localparam int WCOL_POS  = 3;
    localparam int EN_POS    = 2;
    localparam int IE_POS    = 0;
    // Status codes, prescaler bits masked
    localparam logic [7:0] ST_START   = 8'h08;
    localparam logic [7:0] ST_REP     = 8'h10;
    localparam logic [7:0] ST_AW_ACK  = 8'h18;
    localparam logic [7:0] ST_AW_NACK = 8'h20;
    localparam logic [7:0] ST_D_ACK   = 8'h28;
    localparam logic [7:0] ST_D_NACK  = 8'h30;
    localparam logic [7:0] ST_LOST    = 8'h38;
    localparam logic [7:0] ST_AR_ACK  = 8'h40;
    localparam logic [7:0] ST_AR_NACK = 8'h48;
    localparam logic [7:0] ST_IDLE    = 8'hf8;
    // Serial clock timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_PERIOD_NS = 1000;
    localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam logic [4:0] QTR_LAST = 5'(QTR_CYC - 1);
    localparam logic [3:0] ACK_BIT = 4'h8;
    typedef enum logic [2:0] {IDLE, WAITFREE, START, BIT, HOLD, STOP, LOST} state_t;
endpackage

/* File: test/i2c_master_tx_test.sv */
// Self-checking bench for the two-wire master transmitter
`timescale 1ns/1ps
`default_nettype none
module i2c_master_tx_test;
    import i2c_mstx_pkg::*;
    logic       clk    = 1'b0;
    logic       reset  = 1'b1;
    logic [1:0] addr   = 2'h0;
    logic [7:0] wdata  = 8'h00;
    logic       wr     = 1'b0;
    logic       rd     = 1'b0;
    logic       ackOn  = 1'b1;
    logic       jam    = 1'b0;
    logic [7:0] rdata, lastByte, got, adr;
    logic       irq, sdaOut, sdaOeN, sclOut, sclOeN, sdaRel, sdaW, sclW;
    int         nStop, nByte, s0, n_fail = 0, checks = 0;

    assign sdaW = (sdaOeN ? 1'b1 : sdaOut) & sdaRel;
    assign sclW = sclOeN ? 1'b1 : sclOut;
    always #4 clk = ~clk;

    i2c_master_tx i2c_master_tx_inst (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .sdaIn(sdaW), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .sclIn(sclW), .sclOut(sclOut), .sclOeN(sclOeN));
    i2c_slave_model i2c_slave_model_inst (.scl(sclW), .sda(sdaW), .ackOn(ackOn), .jam(jam),
        .sdaRel(sdaRel), .lastByte(lastByte), .nStop(nStop), .nByte(nByte));

    function automatic logic [7:0] expCode(input logic isAddr, input logic ack);
        return isAddr ? (ack ? ST_AW_ACK : ST_AW_NACK) : (ack ? ST_D_ACK : ST_D_NACK);
    endfunction

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrReg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rdReg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Flag is seen through irq; irq enable is set in every control write except the 8'h04 masking write
    task automatic waitFlag(input logic [7:0] exp);
        int i;
        i = 0;
        idle(2);
        while (irq !== 1'b1 && i < 3000)
        begin
            @(posedge clk);
            i++;
        end
        check("irq", 8'h01, {7'h00, irq});
        rdReg(ADDR_STAT, got);
        check("status", exp, got & 8'hf8);
    endtask

    task automatic quiet(input int n);
        idle(n);
        check("irq quiet", 8'h00, {7'h00, irq});
        check("wires released", 8'h03, {6'h00, sdaOeN, sclOeN});
        check("open drain zero", 8'h00, {6'h00, sdaOut, sclOut});
    endtask

    task automatic sendByte(input logic [7:0] b, input logic isAddr, input logic ack);
        ackOn <= ack;
        wrReg(ADDR_DATA, b);
        rdReg(ADDR_DATA, got);
        check("data reg", b, got);
        wrReg(ADDR_CTRL, 8'h85);
        waitFlag(expCode(isAddr, ack));
        check("byte on wire", b, lastByte);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #(80000 * 8);
        n_fail++;
        $display("[ERR] watchdog expected finish seen timeout");
        wrap_up();
    end

    initial
    begin
        void'($urandom(43270));
        idle(10);
        reset <= 1'b0;
        idle(1);
        rdReg(ADDR_CTRL, got);
        check("ctrl reset", 8'h00, got);
        rdReg(2'h3, got);
        check("unmapped", 8'h00, got);
        wrReg(ADDR_STAT, 8'h03);
        rdReg(ADDR_STAT, got);
        check("prescaler", 8'h03, got);
        wrReg(ADDR_DATA, 8'h5a);
        rdReg(ADDR_CTRL, got);
        check("collision", 8'h08, got & 8'h08);
        rdReg(ADDR_DATA, got);
        check("data kept", 8'h00, got);
        $display("test registers done");
        jam <= 1'b1;
        wrReg(ADDR_CTRL, 8'ha5);
        idle(600);
        check("busy bus", 8'h01, {7'h00, sclOeN});
        jam <= 1'b0;
        waitFlag(ST_START);
        wrReg(ADDR_CTRL, 8'h04);
        idle(2);
        check("irq masked", 8'h00, {7'h00, irq});
        rdReg(ADDR_CTRL, got);
        check("flag held", 8'h80, got & 8'h80);
        wrReg(ADDR_CTRL, 8'h05);
        $display("test start done");
        adr = {7'($urandom), 1'b0};
        sendByte(adr, 1'b1, 1'b1);
        for (int i = 0; i < 4; i++)
            sendByte(8'($urandom), 1'b0, 1'(i));
        s0 = nByte;
        idle(300);
        check("suspended", 8'(s0), 8'(nByte));
        check("scl held low", 8'h00, {7'h00, sclOeN});
        $display("test data done");
        s0 = nStop;
        wrReg(ADDR_CTRL, 8'ha5);
        waitFlag(ST_REP);
        check("no stop", 8'(s0), 8'(nStop));
        sendByte(adr, 1'b1, 1'b0);
        wrReg(ADDR_CTRL, 8'hb5);
        waitFlag(ST_START);
        check("stop then start", 8'(s0 + 1), 8'(nStop));
        rdReg(ADDR_CTRL, got);
        check("stop bit", 8'h00, got & 8'h10);
        $display("test restart done");
        sendByte(adr, 1'b1, 1'b1);
        wrReg(ADDR_CTRL, 8'ha5);
        waitFlag(ST_REP);
        wrReg(ADDR_DATA, adr | 8'h01);
        wrReg(ADDR_CTRL, 8'h85);
        waitFlag(ST_AR_ACK);
        s0 = nStop;
        wrReg(ADDR_CTRL, 8'h95);
        quiet(600);
        check("stop sent", 8'(s0 + 1), 8'(nStop));
        rdReg(ADDR_CTRL, got);
        check("stop cleared", 8'h00, got & 8'h10);
        $display("test read and stop done");
        wrReg(ADDR_CTRL, 8'ha5);
        waitFlag(ST_START);
        wrReg(ADDR_DATA, adr | 8'h80);
        wrReg(ADDR_CTRL, 8'h85);
        idle(20);
        jam <= 1'b1;
        waitFlag(ST_LOST);
        jam <= 1'b0;
        wrReg(ADDR_CTRL, 8'h85);
        quiet(600);
        wrReg(ADDR_CTRL, 8'ha5);
        waitFlag(ST_START);
        wrReg(ADDR_DATA, 8'hff);
        wrReg(ADDR_CTRL, 8'h85);
        idle(20);
        jam <= 1'b1;
        waitFlag(ST_LOST);
        wrReg(ADDR_CTRL, 8'ha5);
        idle(300);
        check("retry waits", 8'h01, {7'h00, sclOeN});
        jam <= 1'b0;
        waitFlag(ST_START);
        wrReg(ADDR_CTRL, 8'h95);
        quiet(600);
        $display("test arbitration done");
        wrap_up();
    end
endmodule // i2c_master_tx_test
`default_nettype wire

/* File: test/i2c_slave_model.sv */
// Behavioural slave receiver on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model (
    // Bus wires
    input  wire logic       scl,
    input  wire logic       sda,
    // Bench controls
    input  wire logic       ackOn,
    input  wire logic       jam,
    // Drive and observation
    output logic            sdaRel,
    output logic      [7:0] lastByte,
    output var int          nStop,
    output var int          nByte
);
    logic [3:0] bitCnt = 4'h0;
    logic [7:0] shift  = 8'h00;
    logic       ackDrv = 1'b0;

    // Released line floats to the pull-up; jam stands in for a rival master
    assign sdaRel = ~(ackDrv | jam);

    initial
    begin
        lastByte = 8'h00;
        nStop = 0;
        nByte = 0;
    end

    always @(negedge sda)
        if (scl)
            bitCnt = 4'h0;

    always @(posedge sda)
        if (scl)
        begin
            nStop++;
            bitCnt = 4'h0;
        end

    always @(posedge scl)
        if (bitCnt < 4'h8)
        begin
            shift = {shift[6:0], sda};
            bitCnt++;
            if (bitCnt == 4'h8)
            begin
                lastByte = shift;
                nByte++;
            end
        end
        else
            bitCnt = 4'h9;

    // Acknowledge held through the whole ninth clock, released on its fall
    always @(negedge scl)
        if (bitCnt == 4'h8)
            ackDrv = ackOn;
        else if (bitCnt == 4'h9)
        begin
            ackDrv = 1'b0;
            bitCnt = 4'h0;
        end
endmodule // i2c_slave_model
`default_nettype wire
